/* bench/pic_pin_model.sv */
// board-side source for the six raw port pins
// assumes one bench process calls its tasks, always just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module pic_pin_model (
    input  wire logic  i_clock,  // system clock
    output logic [5:0] o_pins    // pin levels seen by the port
);
    // pins are always driven: a floating input is never left to the simulator
    initial o_pins = 6'h00;
    // new levels land just after an edge, like a clean board driver
    task automatic set_pins(input logic [5:0] v);
        @(posedge i_clock);
        o_pins <= v;
    endtask
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// directed bench for pic_top: avalon access tasks and pin, mode and pad stimulus
// assumes the pin model owns the raw pins and this module owns every other input
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [3:0] A_FE = pic_pkg::OFS_FILTER_EDGE;
    localparam logic [3:0] A_WS = pic_pkg::OFS_WAKE_SOURCE;
    localparam logic [3:0] A_MK = pic_pkg::OFS_IRQ_MASK;
    localparam logic [3:0] A_FL = pic_pkg::OFS_IRQ_FLAG;
    logic                  clk, nrst, rd, wr, dbsel, fast, e;
    logic [3:0]            addr;
    logic [31:0]           wdata, rdata, q;
    logic                  waitreq, bt1, bt2, bt3, cs0, cs1, wake;
    logic [5:0]            pins, pu, pd;
    logic [1:0]            irq;
    pic_pkg::pic_mode_t    mode;
    pic_pkg::pic_pad_cfg_t pad;
    int                    mismatches, samples_checked, n, per;

    pic_top pic_top_i (
        .i_clock(clk), .i_nrst(nrst), .i_address(addr), .i_read(rd), .i_write(wr),
        .i_writedata(wdata), .o_readdata(rdata), .o_waitrequest(waitreq),
        .i_port_pins(pins), .i_mode(mode), .i_debounce_clock_select(dbsel),
        .i_fast_option(fast), .i_pad_cfg(pad), .o_irq_req(irq),
        .o_branch_test_one(bt1), .o_branch_test_two(bt2), .o_branch_test_three(bt3),
        .o_count_src0(cs0), .o_count_src1(cs1), .o_wake(wake), .o_pullup(pu),
        .o_pulldn(pd)
    );
    pic_pin_model pic_pin_model_i (.i_clock(clk), .o_pins(pins));

    // 200 MHz system clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input string name, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
    endtask
    // one avalon access, held until waitrequest is sampled low at an edge
    task automatic bus(input logic r, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        rd <= r;
        wr <= ~r;
        addr <= a;
        wdata <= d;
        do begin
            @(posedge clk);
            k++;
        end while (waitreq !== 1'b0 && k < 50);
        if (k >= 50) check("bus answer", 0, 1);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input string name, input logic [3:0] a, input logic [31:0] x);
        bus(1'b1, a, 32'h0);
        check(name, q, x);
    endtask
    // counts request pulses of one channel; a pulse stands one cycle
    task automatic cnt(input int ch, input int c);
        n = 0;
        repeat (c) begin
            @(posedge clk);
            n += int'(irq[ch] === 1'b1);
        end
    endtask
    task automatic pull_chk(input logic [5:0] eu, ed);
        cyc(3);
        check("pullup", pu, eu);
        check("pulldn", pd, ed);
        check("pull overlap", pu & pd, 32'h0);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // the whole run is well under 12000 cycles, so this only catches a hang
    initial begin
        cyc(40000);
        mismatches++;
        results();
    end

    initial begin
        nrst = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
        dbsel = 1'b0;
        fast = 1'b0;
        mode = pic_pkg::PIC_ACTIVE;
        pad = '0;
        pad.pullup_mask_option = 6'h3F;
        pad.pulldown_mask_option = 6'h3F;
        mismatches = 0;
        samples_checked = 0;
        cyc(16);
        nrst <= 1'b1;
        rd_chk("filter_edge", A_FE, 32'h0);
        rd_chk("wake_source", A_WS, 32'h0);
        rd_chk("irq_mask", A_MK, 32'h0);
        rd_chk("irq_flag", A_FL, 32'h0);
        pull_chk(6'h00, 6'h3F);
        bus(1'b0, A_FE, 32'hFFFF_FFFF);
        rd_chk("filter_edge rw", A_FE, 32'hF);
        bus(1'b0, 4'h2, 32'hF);
        rd_chk("unmapped", 4'h2, 32'h0);
        bus(1'b0, A_FE, 32'h0);
        // debounce at stage 8, 11 and 14: tick spacing 256, 32 and 4 cycles
        // late check sits at two tick spacings plus the pipeline: the worst case
        for (int i = 0; i < 3; i++) begin
            dbsel <= (i > 0);
            fast <= (i == 2);
            per = (i == 0) ? 256 : (i == 1) ? 32 : 4;
            e = (i % 2 == 0);
            cyc(3 * per);
            pic_pin_model_i.set_pins(pins ^ 6'h01);
            cyc(per);
            check("debounce early", bt1, !e);
            cyc(per + 8);
            check("debounce late", bt1, e);
        end
        // debouncer frozen while asleep, no wake without enable
        mode <= pic_pkg::PIC_SLEEP;
        pic_pin_model_i.set_pins(6'h00);
        cyc(60);
        check("sleep debounce", bt1, 1'b1);
        check("wake disabled", wake, 1'b0);
        mode <= pic_pkg::PIC_ACTIVE;
        cyc(60);
        check("active debounce", bt1, 1'b0);
        // alternate source pins for both channels
        bus(1'b0, A_WS, 32'h3);
        pic_pin_model_i.set_pins(6'h30);
        cyc(60);
        check("chan a pin5", bt1, 1'b1);
        check("chan b pin4", bt2, 1'b1);
        bus(1'b0, A_WS, 32'h0);
        cyc(60);
        check("chan a pin0", bt1, 1'b0);
        check("chan b pin3", bt2, 1'b0);
        // debounced request comes only after two ticks
        bus(1'b0, A_MK, 32'h3);
        pic_pin_model_i.set_pins(6'h01);
        cnt(0, 6);
        check("debounced irq early", n, 0);
        cnt(0, 40);
        check("debounced irq", n, 1);
        bus(1'b0, A_FE, 32'hC);
        bus(1'b0, A_FL, 32'h3);
        rd_chk("flag cleared", A_FL, 32'h0);
        pic_pin_model_i.set_pins(6'h00);
        cnt(0, 12);
        check("fall under rise", n, 0);
        pic_pin_model_i.set_pins(6'h01);
        cnt(0, 12);
        check("rise irq", n, 1);
        rd_chk("flag a", A_FL, 32'h1);
        bus(1'b0, A_FL, 32'h1);
        pic_pin_model_i.set_pins(6'h00);
        cnt(0, 12);
        check("idle", n, 0);
        bus(1'b0, A_FE, 32'hD);
        cnt(0, 12);
        check("edge switch irq", n, 1);
        pic_pin_model_i.set_pins(6'h01);
        cnt(0, 12);
        check("rise under fall", n, 0);
        pic_pin_model_i.set_pins(6'h00);
        cnt(0, 12);
        check("fall irq", n, 1);
        // edges while masked are not stored
        bus(1'b0, A_MK, 32'h0);
        pic_pin_model_i.set_pins(6'h01);
        pic_pin_model_i.set_pins(6'h00);
        cnt(0, 12);
        check("masked irq", n, 0);
        bus(1'b0, A_MK, 32'h3);
        cnt(0, 12);
        check("after unmask", n, 0);
        pic_pin_model_i.set_pins(6'h08);
        cnt(1, 40);
        check("chan b irq", n, 1);
        rd_chk("flags both", A_FL, 32'h3);
        // counter event clocks
        bus(1'b0, A_FE, 32'hE);
        cyc(8);
        check("src1 inverted", cs1, 1'b0);
        check("test two level", bt2, 1'b1);
        bus(1'b0, A_FE, 32'hC);
        cyc(8);
        check("src1 direct", cs1, 1'b1);
        pic_pin_model_i.set_pins(6'h0A);
        cyc(6);
        check("src0 high", cs0, 1'b1);
        pic_pin_model_i.set_pins(6'h08);
        cyc(6);
        check("src0 low", cs0, 1'b0);
        // wake on change only while asleep
        bus(1'b0, A_WS, 32'h4);
        mode <= pic_pkg::PIC_SLEEP;
        cyc(5);
        check("wake idle", wake, 1'b0);
        pic_pin_model_i.set_pins(6'h09);
        cyc(4);
        check("wake", wake, 1'b1);
        mode <= pic_pkg::PIC_ACTIVE;
        cyc(4);
        check("wake active", wake, 1'b0);
        // reset in mid-run; pin 1 stays low so the pin 1 path holds across it
        nrst <= 1'b0;
        cyc(4);
        check("reset irq", irq, 32'h0);
        check("reset wake", wake, 1'b0);
        nrst <= 1'b1;
        rd_chk("mask after reset", A_MK, 32'h0);
        rd_chk("filter after reset", A_FE, 32'h0);
        rd_chk("wake after reset", A_WS, 32'h0);
        rd_chk("flag after reset", A_FL, 32'h0);
        // pull resistor combinations
        pad.open_drain_select <= 6'h3F;
        pull_chk(6'h2F, 6'h10);
        pad.output_enable_bit <= 6'h01;
        pull_chk(6'h2E, 6'h10);
        pad.pin4_pull_up <= 1'b1;
        pull_chk(6'h3E, 6'h00);
        pad.pin4_pull_remove <= 1'b1;
        pad.open_drain_select <= 6'h00;
        pad.pulldown_cut <= 6'h02;
        pull_chk(6'h00, 6'h2D);
        // on pins other than 4, only fitted resistors switch and a driven pin keeps pull-up only while it drives one
        pad.pin4_pull_remove <= 1'b0;
        pad.open_drain_select <= 6'h3F;
        pad.pulldown_cut <= 6'h00;
        pad.output_enable_bit <= 6'h3F;
        pad.pin_data_bit <= 6'h3F;
        pad.pullup_mask_option <= 6'h15;
        pad.pulldown_mask_option <= 6'h2A;
        pull_chk(6'h15, 6'h00);
        pad.pin_data_bit <= 6'h00;
        pull_chk(6'h10, 6'h00);
        pad.open_drain_select <= 6'h00;
        pull_chk(6'h10, 6'h2A);
        check("test three", bt3, 1'b0);
        results();
    end
endmodule
`default_nettype wire

/* core/pic_debounce.sv */
// one debounce channel: two-stage stable-level filter
// assumes a one-cycle tick per debounce clock rising edge
`timescale 1ns/1ps
`default_nettype none
module pic_debounce (
    input  wire logic i_clock,    // system clock
    input  wire logic i_nrst,     // async reset, active low
    input  wire logic i_tick,     // debounce clock rising edge
    input  wire logic i_level,    // synchronised input
    output logic      o_level     // accepted level
);
    logic samp_reg, samp_next, chg_reg, chg_next, acc_reg, acc_next;
    // a change between ticks spoils the next comparison
    always_comb begin
        samp_next = samp_reg;
        chg_next  = chg_reg | (i_level != samp_reg);
        acc_next  = acc_reg;
        if (i_tick) begin
            if (!chg_next) begin
                acc_next = samp_reg;
            end
            samp_next = i_level;
            chg_next  = 1'b0;
        end
    end
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            samp_reg <= 1'b0;
            chg_reg  <= 1'b0;
            acc_reg  <= 1'b0;
        end else begin
            samp_reg <= samp_next;
            chg_reg  <= chg_next;
            acc_reg  <= acc_next;
        end
    end
    assign o_level = acc_reg;
    debounce_hold_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        !i_tick |=> $stable(o_level)) else $error("level moved without tick");
endmodule
`default_nettype wire

/* core/pic_pkg.sv */
// shared constants and types for the port input conditioning block
// assumes a single system clock domain; no imports, users write pic_pkg::name
package pic_pkg;
    // register byte offsets on the avalon slave
    localparam logic [3:0] OFS_FILTER_EDGE = 4'h0;
    localparam logic [3:0] OFS_WAKE_SOURCE = 4'h4;
    localparam logic [3:0] OFS_IRQ_MASK    = 4'h8;
    localparam logic [3:0] OFS_IRQ_FLAG    = 4'hC;
    // control field positions
    localparam int B_FALL_A   = 0;
    localparam int B_FALL_B   = 1;
    localparam int B_DEBDIS_A = 2;
    localparam int B_DEBDIS_B = 3;
    localparam int B_PSEL_A   = 0;
    localparam int B_PSEL_B   = 1;
    localparam int B_WAKE_A   = 2;
    localparam int B_WAKE_B   = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [1:0] MASK_RESET = 2'h0;
    // prescaler stages used as debounce clocks
    localparam int STAGE_SLOW = 8;
    localparam int STAGE_MID  = 11;
    localparam int STAGE_FAST = 14;
    localparam int PRESC_W    = 17;
    typedef enum logic [1:0] {
        PIC_ACTIVE  = 2'b00,
        PIC_STANDBY = 2'b01,
        PIC_SLEEP   = 2'b11
    } pic_mode_t;
    // per-pin pad configuration carried as one group
    typedef struct packed {
        logic [5:0] pulldown_cut;
        logic [5:0] open_drain_select;
        logic [5:0] output_enable_bit;
        logic [5:0] pin_data_bit;
        logic [5:0] pullup_mask_option;
        logic [5:0] pulldown_mask_option;
        logic       pin4_pull_remove;
        logic       pin4_pull_up;
    } pic_pad_cfg_t;
endpackage

/* core/pic_pull.sv */
// pull resistor control for the six port pins
// assumes pad configuration is static between writes
`timescale 1ns/1ps
`default_nettype none
module pic_pull (
    input  wire logic                  i_clock,   // system clock
    input  wire logic                  i_nrst,    // async reset, active low
    input  wire pic_pkg::pic_pad_cfg_t i_cfg,     // pad configuration
    output logic [5:0]                 o_pullup,  // pull-up enables
    output logic [5:0]                 o_pulldn   // pull-down enables
);
    logic [5:0] up_next, dn_next, up_reg, dn_reg;
    // pin 4 has one resistor whose direction is a strap; pin 4 has no open-drain path
    always_comb begin
        for (int n = 0; n < 6; n++) begin
            dn_next[n] = i_cfg.pulldown_mask_option[n] & ~i_cfg.pulldown_cut[n]
                       & ~i_cfg.open_drain_select[n];
            up_next[n] = i_cfg.pullup_mask_option[n] & i_cfg.open_drain_select[n]
                       & (~i_cfg.output_enable_bit[n] | i_cfg.pin_data_bit[n]);
        end
        up_next[4] = ~i_cfg.pin4_pull_remove & i_cfg.pin4_pull_up;
        dn_next[4] = ~i_cfg.pin4_pull_remove & ~i_cfg.pin4_pull_up;
        dn_next    = dn_next & ~up_next;
    end
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            up_reg <= 6'h00;
            dn_reg <= 6'h00;
        end else begin
            up_reg <= up_next;
            dn_reg <= dn_next;
        end
    end
    assign o_pullup = up_reg;
    assign o_pulldn = dn_reg;
    pull_exclusive_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (o_pullup & o_pulldn) == 6'h00) else $error("pull up and down together");
    pulldown_od_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        $past(i_cfg.open_drain_select[0]) |-> !o_pulldn[0]) else $error("od pulldown");
endmodule
`default_nettype wire

/* core/pic_top.sv */
// port input conditioning: channel select, debounce, edge irq, wake, tests, pulls
// assumes synchronous avalon master and a prescaler held here that runs only in active and standby
//
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module pic_top (
    input  wire logic                  i_clock,        // 200 MHz system clock
    input  wire logic                  i_nrst,         // async reset, active low
    input  wire logic [3:0]            i_address,      // avalon byte address
    input  wire logic                  i_read,         // avalon read
    input  wire logic                  i_write,        // avalon write
    input  wire logic [31:0]           i_writedata,    // avalon write data
    output logic [31:0]                o_readdata,     // avalon read data
    output logic                       o_waitrequest,  // avalon wait
    input  wire logic [5:0]            i_port_pins,    // raw pin levels
    input  wire pic_pkg::pic_mode_t    i_mode,         // power mode
    input  wire logic                  i_debounce_clock_select, // prescaler control bit
    input  wire logic                  i_fast_option,  // picks stage 14 over 11
    input  wire pic_pkg::pic_pad_cfg_t i_pad_cfg,      // pad configuration
    output logic [1:0]                 o_irq_req,      // masked request pulses
    output logic                       o_branch_test_one,   // channel a level
    output logic                       o_branch_test_two,   // channel b level
    output logic                       o_branch_test_three, // always low
    output logic                       o_count_src0,   // pin 1 event clock
    output logic                       o_count_src1,   // channel b event clock
    output logic                       o_wake,         // wake from sleep
    output logic [5:0]                 o_pullup,       // pull-up enables
    output logic [5:0]                 o_pulldn        // pull-down enables
);
    // synchroniser stages and prescaler
    logic [5:0] sync1_reg, sync2_reg;
    logic [pic_pkg::PRESC_W-1:0] presc_reg, presc_next;
    logic [pic_pkg::PRESC_W-1:0] tap_reg;
    logic deb_tap, deb_tap_d_reg, deb_tick, clk_run;

    // two flops per pin; only sync2 is used downstream
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            sync1_reg <= 6'h00;
            sync2_reg <= 6'h00;
        end else begin
            sync1_reg <= i_port_pins;
            sync2_reg <= sync1_reg;
        end
    end

    // prescaler: stops outside active and standby, so the debouncer freezes
    assign clk_run = (i_mode == pic_pkg::PIC_ACTIVE) || (i_mode == pic_pkg::PIC_STANDBY);
    always_comb begin
        presc_next = clk_run ? presc_reg + 1'b1 : presc_reg;
    end
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            presc_reg <= '0;
        end else begin
            presc_reg <= presc_next;
        end
    end
    assign tap_reg = presc_reg;

    // stage n is counter bit 15-n, period 2^(16-n) clocks; two stage 8 ticks make 512 clocks
    always_comb begin
        if (!i_debounce_clock_select) begin
            deb_tap = tap_reg[15 - pic_pkg::STAGE_SLOW];
        end else if (i_fast_option) begin
            deb_tap = tap_reg[15 - pic_pkg::STAGE_FAST];
        end else begin
            deb_tap = tap_reg[15 - pic_pkg::STAGE_MID];
        end
    end
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            deb_tap_d_reg <= 1'b0;
        end else begin
            deb_tap_d_reg <= deb_tap;
        end
    end
    assign deb_tick = deb_tap & ~deb_tap_d_reg & clk_run;

    // software registers
    logic [3:0] filt_reg, filt_next, wsrc_reg, wsrc_next;
    logic [1:0] mask_reg, mask_next, flag_reg, flag_next;
    logic [31:0] rdata_reg, rdata_next;
    logic       wait_reg, wait_next;

    // channel sources and conditioning
    logic [1:0] raw_ch, deb_ch, sel_ch, pol_ch, pol_d_reg, edge_ch;
    assign raw_ch[0] = wsrc_reg[pic_pkg::B_PSEL_A] ? sync2_reg[5] : sync2_reg[0];
    assign raw_ch[1] = wsrc_reg[pic_pkg::B_PSEL_B] ? sync2_reg[4] : sync2_reg[3];

    // one debouncer per channel
    generate
        for (genvar c = 0; c < 2; c++) begin : g_deb
            pic_debounce u_deb (
                .i_clock (i_clock),
                .i_nrst  (i_nrst),
                .i_tick  (deb_tick),
                .i_level (raw_ch[c]),
                .o_level (deb_ch[c])
            );
        end
    endgenerate

    // debounce on when the disable bit is low; polarity set by falling select
    assign sel_ch[0] = filt_reg[pic_pkg::B_DEBDIS_A] ? raw_ch[0] : deb_ch[0];
    assign sel_ch[1] = filt_reg[pic_pkg::B_DEBDIS_B] ? raw_ch[1] : deb_ch[1];
    assign pol_ch[0] = sel_ch[0] ^ filt_reg[pic_pkg::B_FALL_A];
    assign pol_ch[1] = sel_ch[1] ^ filt_reg[pic_pkg::B_FALL_B];
    // edge select switching to rising while high, or to falling while low, looks like an edge: that is the documented hazard
    assign edge_ch = pol_ch & ~pol_d_reg;

    // bus slave: one wait cycle, then answer; unmapped reads zero
    logic acc_now;
    assign acc_now = (i_read | i_write) & wait_reg;
    always_comb begin
        filt_next  = filt_reg;
        wsrc_next  = wsrc_reg;
        mask_next  = mask_reg;
        rdata_next = rdata_reg;
        wait_next  = 1'b1;
        // hardware set wins over software clear
        flag_next  = flag_reg;
        if (acc_now) begin
            wait_next = 1'b0;
            if (i_write) begin
                case (i_address)
                    pic_pkg::OFS_FILTER_EDGE: filt_next = i_writedata[3:0];
                    pic_pkg::OFS_WAKE_SOURCE: wsrc_next = i_writedata[3:0];
                    pic_pkg::OFS_IRQ_MASK:    mask_next = i_writedata[1:0];
                    pic_pkg::OFS_IRQ_FLAG:    flag_next = flag_reg & ~i_writedata[1:0];
                    default:                  filt_next = filt_reg;
                endcase
            end else begin
                case (i_address)
                    pic_pkg::OFS_FILTER_EDGE: rdata_next = {28'h0000000, filt_reg};
                    pic_pkg::OFS_WAKE_SOURCE: rdata_next = {28'h0000000, wsrc_reg};
                    pic_pkg::OFS_IRQ_MASK:    rdata_next = {30'h00000000, mask_reg};
                    pic_pkg::OFS_IRQ_FLAG:    rdata_next = {30'h00000000, flag_reg};
                    default:                  rdata_next = 32'h00000000;
                endcase
            end
        end
        // only edges seen while unmasked are stored, so old edges are dropped
        flag_next = flag_next | (edge_ch & mask_reg);
    end
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            filt_reg  <= pic_pkg::CTRL_RESET;
            wsrc_reg  <= pic_pkg::CTRL_RESET;
            mask_reg  <= pic_pkg::MASK_RESET;
            flag_reg  <= 2'h0;
            rdata_reg <= 32'h00000000;
            wait_reg  <= 1'b1;
            pol_d_reg <= 2'h0;
        end else begin
            filt_reg  <= filt_next;
            wsrc_reg  <= wsrc_next;
            mask_reg  <= mask_next;
            flag_reg  <= flag_next;
            rdata_reg <= rdata_next;
            wait_reg  <= wait_next;
            pol_d_reg <= pol_ch;
        end
    end

    // outputs, all from flops except test three, which is tied low
    logic [1:0] irq_reg, irq_next, wake_ref_reg;
    logic tst1_reg, tst2_reg, src0_reg, src1_reg, wake_reg, wake_next;
    always_comb begin
        irq_next  = edge_ch & mask_reg;
        // wake compares against the level frozen on sleep entry, no debounce clock needed
        wake_next = (i_mode == pic_pkg::PIC_SLEEP) &&
                    (|(wsrc_reg[3:2] & (raw_ch ^ wake_ref_reg)));
    end
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_reg      <= 2'h0;
            tst1_reg     <= 1'b0;
            tst2_reg     <= 1'b0;
            src0_reg     <= 1'b0;
            src1_reg     <= 1'b0;
            wake_reg     <= 1'b0;
            wake_ref_reg <= 2'h0;
        end else begin
            irq_reg  <= irq_next;
            tst1_reg <= deb_ch[0];
            tst2_reg <= deb_ch[1];
            src0_reg <= sync2_reg[1];
            src1_reg <= pol_ch[1];
            wake_reg <= wake_next;
            if (i_mode != pic_pkg::PIC_SLEEP) begin
                wake_ref_reg <= raw_ch;
            end
        end
    end

    pic_pull u_pull (
        .i_clock  (i_clock),
        .i_nrst   (i_nrst),
        .i_cfg    (i_pad_cfg),
        .o_pullup (o_pullup),
        .o_pulldn (o_pulldn)
    );

    assign o_readdata          = rdata_reg;
    assign o_waitrequest       = wait_reg;
    assign o_irq_req           = irq_reg;
    assign o_branch_test_one   = tst1_reg;
    assign o_branch_test_two   = tst2_reg;
    assign o_branch_test_three = 1'b0;
    assign o_count_src0        = src0_reg;
    assign o_count_src1        = src1_reg;
    assign o_wake              = wake_reg;

    // checks
    irq_masked_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        o_irq_req[0] |-> $past(mask_reg[0])) else $error("irq while masked");
    flag_set_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        o_irq_req[1] |-> flag_reg[1]) else $error("request without flag");
    wake_sleep_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        o_wake |-> $past(i_mode) == pic_pkg::PIC_SLEEP) else $error("wake outside sleep");
    test_three_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        !o_branch_test_three) else $error("third test input high");
    src_direct_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        ##2 o_count_src0 == $past(i_port_pins[1], 3)) else $error("pin 1 path wrong");
    wait_one_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (i_read && o_waitrequest) |=> !o_waitrequest) else $error("answer late");
    prescale_stop_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        (i_mode == pic_pkg::PIC_SLEEP) |=> presc_reg == $past(presc_reg))
        else $error("prescaler ran in sleep");
    test_one_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
        o_branch_test_one == $past(deb_ch[0])) else $error("test one not debounced");
    irq_cov_c: cover property (@(posedge i_clock) o_irq_req[0]);
    wake_cov_c: cover property (@(posedge i_clock) o_wake);
    flag_clr_c: cover property (@(posedge i_clock) $fell(flag_reg[0]));
endmodule
`default_nettype wire
